// ---- cscw_regs.sv ----
`timescale 1ns/10ps
module cscw_regs
	import cscw_pkg::*;
(
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_in,
	input  wire logic                 global_reset_n_in,
	input  wire logic                 bus_reset_n_in,
	input  wire logic                 pme_enable_in,
	input  wire logic                 diag_pci_route_in,
	input  wire logic                 clear_on_write_in,
	input  wire cscw_req_t            req_in,
	input  wire cscw_src_t [1:0]      src_in,
	input  wire logic [1:0][4:0]      mem_hit_in,
	input  wire logic [1:0][1:0]      io_hit_in,
	output logic [7:0]                rdata_out,
	output logic                      claim_out,
	output logic [1:0]                pci_irq_out,
	output logic [1:0][3:0]           isa_route_out,
	output logic [1:0][7:0]           window_enable_out
);
	// pin inputs pass two flops; first stage feeds only the second
	cscw_src_t [1:0] s1_reg, s2_reg, s3_reg;
	logic gr1_reg, gr2_reg, br1_reg, br2_reg;
	logic [1:0][7:0] cfg_reg, cfg_next, wen_reg, wen_next;
	logic [1:0][3:0] flag_reg, flag_next;
	logic [7:0] rdata_reg, rdata_next;
	logic soft_rst, en_rst;

	function automatic logic [3:0] src_bits(input cscw_src_t s);
		src_bits = {s.card_detect, s.ready, s.battery_warn, s.battery_dead};
	endfunction : src_bits

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			gr1_reg <= 1'b0;
			gr2_reg <= 1'b0;
			br1_reg <= 1'b0;
			br2_reg <= 1'b0;
		end else begin
			s1_reg <= src_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			gr1_reg <= ~global_reset_n_in;
			gr2_reg <= gr1_reg;
			br1_reg <= ~bus_reset_n_in;
			br2_reg <= br1_reg;
		end
	end

	// pme keeps the event enables (cfg bits 3:0) alive across a bus reset; window enables still clear
	assign soft_rst = gr2_reg | br2_reg;
	assign en_rst = gr2_reg | (br2_reg & ~pme_enable_in);

	always_comb begin
		logic [3:0] cur, prv, ev, en, vis;
		logic [7:0] base;
		logic hit, rd, wr;
		cfg_next = cfg_reg;
		wen_next = wen_reg;
		flag_next = flag_reg;
		rdata_next = rdata_reg;
		cur = '0;
		prv = '0;
		ev = '0;
		en = '0;
		vis = '0;
		base = '0;
		hit = 1'b0;
		rd = req_in.valid & ~req_in.write;
		wr = req_in.valid & req_in.write;
		// any read that no register claims returns zero
		if (rd) begin
			rdata_next = 8'h00;
		end
		for (int k = 0; k < CSCW_NSOCK; k++) begin
			base = (k == 1) ? CSCW_SOCK_STEP : 8'h00;
			cur = src_bits(s2_reg[k]);
			prv = src_bits(s3_reg[k]);
			en = cfg_reg[k][3:0];
			// cd: any change; ready: rising; battery/stschg: assertion
			ev = {cur[3] ^ prv[3], cur[2:0] & ~prv[2:0]};
			vis = flag_reg[k] & en;
			hit = req_in.addr == (base + CSCW_STAT_OFS);
			if (rd && hit && !clear_on_write_in) begin
				flag_next[k] = '0;
			end
			if (wr && hit && clear_on_write_in) begin
				flag_next[k] = flag_reg[k] & ~req_in.wdata[3:0];
			end
			if (rd && hit) begin
				rdata_next = {4'h0, vis};
			end
			if (wr && req_in.addr == (base + CSCW_CFG_OFS)) begin
				cfg_next[k] = req_in.wdata;
			end
			if (rd && req_in.addr == (base + CSCW_CFG_OFS)) begin
				rdata_next = cfg_reg[k];
			end
			if (wr && req_in.addr == (base + CSCW_WEN_OFS)) begin
				wen_next[k] = req_in.wdata & CSCW_WEN_MASK;
			end
			if (rd && req_in.addr == (base + CSCW_WEN_OFS)) begin
				rdata_next = wen_reg[k];
			end
			if (soft_rst) begin
				cfg_next[k][7:4] = CSCW_RESET_VAL[7:4];
				wen_next[k] = CSCW_RESET_VAL;
			end
			if (en_rst) begin
				cfg_next[k][3:0] = CSCW_RESET_VAL[3:0];
			end
			// set wins over clear; masking with the new enables keeps a
			// flag from outliving its enable by one cycle
			if (soft_rst) begin
				flag_next[k] = '0;
			end else begin
				flag_next[k] = (flag_next[k] | (ev & en))
					& cfg_next[k][3:0];
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_reg <= '0;
			wen_reg <= '0;
			flag_reg <= '0;
			rdata_reg <= 8'h00;
		end else begin
			cfg_reg <= cfg_next;
			wen_reg <= wen_next;
			flag_reg <= flag_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_out = rdata_reg;
	assign window_enable_out = wen_reg;

	// limitation: nonzero route codes are passed out undecoded
	always_comb begin
		logic any;
		any = 1'b0;
		claim_out = 1'b0;
		for (int k = 0; k < CSCW_NSOCK; k++) begin
			any = |(flag_reg[k] & cfg_reg[k][3:0]);
			pci_irq_out[k] = any && cfg_reg[k][7:4] == CSCW_ROUTE_PCI
				&& diag_pci_route_in;
			isa_route_out[k] = (any && cfg_reg[k][7:4] != CSCW_ROUTE_PCI)
				? cfg_reg[k][7:4] : 4'h0;
			claim_out = claim_out
				| |(mem_hit_in[k] & wen_reg[k][4:0])
				| |(io_hit_in[k] & wen_reg[k][7:6]);
		end
	end

	wen_reset_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		gr2_reg |=> wen_reg == '0) else $error("window enable not cleared");
	wen_bit5_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		!wen_reg[0][5] && !wen_reg[1][5]) else $error("reserved bit set");
	pme_keep_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(br2_reg && !gr2_reg && pme_enable_in
		&& !(req_in.valid && req_in.write)) |=>
		cfg_reg[1][3:0] == $past(cfg_reg[1][3:0]))
		else $error("enables lost on bus reset");
	en_clear_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(br2_reg && !pme_enable_in) |=> cfg_reg[1][3:0] == '0)
		else $error("enables kept on bus reset");
	flag_mask_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		((flag_reg[0] & ~cfg_reg[0][3:0])
		| (flag_reg[1] & ~cfg_reg[1][3:0])) == '0)
		else $error("disabled flag latched");
	stat_read_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(req_in.valid && !req_in.write
		&& req_in.addr == CSCW_SOCK_STEP + CSCW_STAT_OFS) |=>
		rdata_out == {4'h0, $past(flag_reg[1] & cfg_reg[1][3:0])})
		else $error("status read wrong");
	rd_clear_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(req_in.valid && !req_in.write && !clear_on_write_in
		&& req_in.addr == CSCW_SOCK_STEP + CSCW_STAT_OFS
		&& s2_reg[1] == s3_reg[1]) |=> flag_reg[1] == '0)
		else $error("flags kept after read");
	wr_clear_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(req_in.valid && req_in.write && clear_on_write_in
		&& req_in.addr == CSCW_SOCK_STEP + CSCW_STAT_OFS
		&& s2_reg[1] == s3_reg[1]) |=>
		(flag_reg[1] & $past(req_in.wdata[3:0])) == '0)
		else $error("flags kept after write");
	pci_route_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(|(flag_reg[1] & cfg_reg[1][3:0]) && cfg_reg[1][7:4] == 4'h0
		&& diag_pci_route_in) |-> pci_irq_out[1])
		else $error("pci interrupt missing");
	irq_or_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		pci_irq_out[1] |-> |(flag_reg[1] & cfg_reg[1][3:0]))
		else $error("interrupt without enabled flag");
	no_isa_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		cfg_reg[1][7:4] == 4'h0 |-> isa_route_out[1] == 4'h0)
		else $error("isa line driven");
	no_claim_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(wen_reg[0] == '0 && wen_reg[1] == '0) |-> !claim_out)
		else $error("claim with windows off");
	mem_claim_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		|(mem_hit_in[0] & wen_reg[0][4:0]) |-> claim_out)
		else $error("memory window not claimed");
	io_claim_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		|(io_hit_in[0] & wen_reg[0][7:6]) |-> claim_out)
		else $error("io window not claimed");
	sock_sep_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(req_in.valid && req_in.write && !soft_rst
		&& req_in.addr == CSCW_SOCK_STEP + CSCW_CFG_OFS) |=>
		cfg_reg[0] == $past(cfg_reg[0]))
		else $error("socket a changed by socket b write");
	cd_event_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(cfg_reg[1][3] && cfg_next[1][3] && !soft_rst
		&& s2_reg[1].card_detect != s3_reg[1].card_detect)
		|=> flag_reg[1][3])
		else $error("card detect change lost");
	rdy_rise_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(cfg_reg[1][2] && cfg_next[1][2] && !soft_rst
		&& s2_reg[1].ready && !s3_reg[1].ready)
		|=> flag_reg[1][2])
		else $error("ready rise lost");
	warn_rise_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(cfg_reg[1][1] && cfg_next[1][1] && !soft_rst
		&& s2_reg[1].battery_warn && !s3_reg[1].battery_warn)
		|=> flag_reg[1][1])
		else $error("battery warning lost");
	dead_rise_a: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(cfg_reg[1][0] && cfg_next[1][0] && !soft_rst
		&& s2_reg[1].battery_dead && !s3_reg[1].battery_dead)
		|=> flag_reg[1][0])
		else $error("battery dead lost");
endmodule : cscw_regs

// ---- cscw_pkg.sv ----
package cscw_pkg;
	localparam logic [7:0] CSCW_CFG_OFS    = 8'h05;
	localparam logic [7:0] CSCW_WEN_OFS    = 8'h06;
	localparam logic [7:0] CSCW_STAT_OFS   = 8'h04;
	localparam logic [7:0] CSCW_SOCK_STEP  = 8'h40;
	localparam logic [3:0] CSCW_ROUTE_PCI  = 4'h0;
	localparam logic [7:0] CSCW_WEN_MASK   = 8'hdf;
	localparam logic [7:0] CSCW_RESET_VAL  = 8'h00;
	localparam int         CSCW_NSRC       = 4;
	localparam int         CSCW_NSOCK      = 2;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cscw_req_t;

	typedef struct packed {
		logic       card_detect;
		logic       ready;
		logic       battery_warn;
		logic       battery_dead;
	} cscw_src_t;
endpackage : cscw_pkg

// ---- cscw_card_model.sv ----
`timescale 1ns/10ps
module cscw_card_model
	import cscw_pkg::*;
(
	input  wire logic            core_clk_in,
	input  wire logic [1:0][3:0] flip_in,
	output cscw_src_t [1:0]      src_out
);
	// card pins: one flip per pin and cycle, so each level holds for cycles
	initial src_out = '0;
	always @(posedge core_clk_in) src_out <= src_out ^ flip_in;
endmodule : cscw_card_model

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top
	import cscw_pkg::*;
;
	logic            clk, rst, global_reset_n_n, brst_n, pme, diag, cow, claim;
	cscw_req_t       req;
	cscw_src_t [1:0] src;
	logic [1:0][4:0] mh;
	logic [1:0][1:0] ih, irq;
	logic [1:0][3:0] flip, isa;
	logic [1:0][7:0] wen;
	logic [7:0]      rdata;
	int              n_mismatch, n_compared;

	cscw_regs cscw_regs_i (.core_clk_in(clk), .rst_in(rst),
		.global_reset_n_in(global_reset_n_n), .bus_reset_n_in(brst_n),
		.pme_enable_in(pme), .diag_pci_route_in(diag),
		.clear_on_write_in(cow), .req_in(req), .src_in(src),
		.mem_hit_in(mh), .io_hit_in(ih), .rdata_out(rdata),
		.claim_out(claim), .pci_irq_out(irq), .isa_route_out(isa),
		.window_enable_out(wen));
	cscw_card_model cscw_card_model_i (.core_clk_in(clk), .flip_in(flip),
		.src_out(src));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic acc(input bit s, input logic [7:0] o, input bit w,
		input logic [7:0] d);
		@(negedge clk);
		req = '{1'b1, w, o | (s ? CSCW_SOCK_STEP : 8'h00), d};
		@(negedge clk);
		req = '0;
		if (!w) chk(rdata, d);
	endtask : acc

	// pins are synced, so allow the sync stages plus the compare
	task automatic ev(input int s, input int b);
		@(negedge clk);
		flip[s][b] = 1'b1;
		@(negedge clk);
		flip = '0;
		repeat (4) @(negedge clk);
	endtask : ev

	task automatic pin_rst(input bit g);
		if (g) global_reset_n_n = 1'b0;
		else brst_n = 1'b0;
		repeat (4) @(negedge clk);
		global_reset_n_n = 1'b1;
		brst_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask : pin_rst

	task automatic stop_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	initial begin
		#(5000 * 100);
		n_mismatch++;
		stop_test();
	end

	initial begin
		{rst, global_reset_n_n, brst_n, diag} = 4'hf;
		{pme, cow} = 2'h0;
		{req, mh, ih, flip} = '0;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		for (int s = 0; s < 2; s++) begin
			acc(s, CSCW_CFG_OFS, 0, CSCW_RESET_VAL);
			acc(s, CSCW_WEN_OFS, 0, CSCW_RESET_VAL);
		end
		$display("reset test done");
		acc(0, CSCW_WEN_OFS, 1, 8'hff);
		acc(0, CSCW_WEN_OFS, 0, 8'hdf);
		chk(wen[0], 8'hdf);
		acc(1, CSCW_WEN_OFS, 0, 8'h00);
		mh[0] = 5'h10;
		#1 chk({7'h0, claim}, 8'h01);
		acc(0, CSCW_WEN_OFS, 1, 8'h40);
		chk({7'h0, claim}, 8'h00);
		ih[0] = 2'b01;
		#1 chk({7'h0, claim}, 8'h01);
		{mh, ih} = '0;
		$display("window test done");
		for (int b = 0; b < 4; b++) begin
			acc(1, CSCW_CFG_OFS, 1, 8'h01 << b);
			ev(1, (b + 3) % 4);
			ev(1, b);
			chk({6'h0, irq}, 8'h02);
			acc(1, CSCW_STAT_OFS, 0, 8'h01 << b);
			chk({6'h0, irq}, 8'h00);
		end
		$display("source test done");
		diag = 1'b0;
		cow = 1'b1;
		ev(1, 3);
		chk({6'h0, irq}, 8'h00);
		chk({4'h0, isa[1]}, 8'h00);
		acc(1, CSCW_CFG_OFS, 1, 8'h98);
		chk({4'h0, isa[1]}, 8'h09);
		acc(1, CSCW_CFG_OFS, 1, 8'h08);
		acc(1, CSCW_STAT_OFS, 0, 8'h08);
		acc(1, CSCW_STAT_OFS, 1, 8'h08);
		acc(1, CSCW_STAT_OFS, 0, 8'h00);
		{diag, cow} = 2'b10;
		$display("clear test done");
		acc(1, CSCW_CFG_OFS, 1, 8'h0f);
		pme = 1'b1;
		pin_rst(0);
		acc(1, CSCW_CFG_OFS, 0, 8'h0f);
		pin_rst(1);
		acc(1, CSCW_CFG_OFS, 0, 8'h00);
		acc(1, CSCW_CFG_OFS, 1, 8'h0f);
		pme = 1'b0;
		pin_rst(0);
		acc(1, CSCW_CFG_OFS, 0, 8'h00);
		$display("reset pin test done");
		stop_test();
	end
endmodule : tb_top
